// ---- logic/llo_level_mux.sv ----
// Selects applied level codes between register and input values
`timescale 1ns/1ps
module llo_level_mux
    import llo_pkg::*;
#(
    parameter int W = LLO_CODE_W
) (
    // Selection
    input wire logic override_i,
    // Register side codes
    input wire logic [W-1:0] reg_tx_i,
    input wire logic [W-1:0] reg_los_i,
    input wire logic [W-1:0] reg_hys_i,
    // Input derived codes
    input wire logic [W-1:0] in_tx_i,
    input wire logic [W-1:0] in_los_i,
    input wire logic [W-1:0] in_hys_i,
    // Applied codes
    output logic [W-1:0] tx_o,
    output logic [W-1:0] los_o,
    output logic [W-1:0] hys_o
);
    // All three controls switch together, never one alone
    assign tx_o = override_i ? reg_tx_i : in_tx_i;
    assign los_o = override_i ? reg_los_i : in_los_i;
    assign hys_o = override_i ? reg_hys_i : in_hys_i;
endmodule

// ---- logic/llo_pkg.sv ----
// Package for the link level override register block
package llo_pkg;
    // Register byte offsets
    localparam logic [11:0] LLO_OVERRIDE_OFFS = 12'h428;
    localparam logic [11:0] LLO_STATUS_OFFS = 12'h420;
    // Override register field layout
    localparam int LLO_EN_BIT = 31;
    localparam int LLO_TX_HI = 30;
    localparam int LLO_TX_LO = 26;
    localparam int LLO_LOS_HI = 25;
    localparam int LLO_LOS_LO = 21;
    localparam int LLO_HYS_HI = 20;
    localparam int LLO_HYS_LO = 16;
    localparam int LLO_RSVD_HI = 15;
    localparam int LLO_CODE_W = 5;
    // Reset values
    localparam logic LLO_EN_RST = 1'b0;
    localparam logic [4:0] LLO_TX_RST = 5'h10;
    localparam logic [4:0] LLO_LOS_RST = 5'h10;
    localparam logic [4:0] LLO_HYS_RST = 5'h10;
    localparam logic [15:0] LLO_RSVD_RST = 16'h0000;
    // Status register bit 31 reads as one, low bits read as ones
    localparam logic LLO_STAT_B31 = 1'b1;
    localparam logic [15:0] LLO_STAT_LOW = 16'hffff;
    // Answer to an unmapped read
    localparam logic [31:0] LLO_UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- logic/llo_regs.sv ----
// Link level override register with Avalon-MM slave and level select
//
// How it works
// - Override bit 31 selects register codes; resets off
// - Transmit amplitude code bits 30:26, reset 0x10
// - Signal loss threshold code bits 25:21, reset 0x10
// - Comparator hysteresis code bits 20:16, reset 0x10
// - Status register shows input codes, not applied
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module llo_regs
    import llo_pkg::*;
#(
    parameter int W = LLO_CODE_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Avalon-MM slave
    input wire logic [11:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Input derived level codes
    input wire logic [W-1:0] in_tx_i,
    input wire logic [W-1:0] in_los_i,
    input wire logic [W-1:0] in_hys_i,
    // Applied level controls
    output logic override_o,
    output logic [W-1:0] tx_o,
    output logic [W-1:0] los_o,
    output logic [W-1:0] hys_o
);
    logic en_q;
    logic [W-1:0] tx_q;
    logic [W-1:0] los_q;
    logic [W-1:0] hys_q;
    logic [15:0] rsvd_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] ovr_word;
    logic [31:0] stat_word;
    logic [31:0] new_word;
    logic hit_ovr;
    logic hit_stat;
    logic req;

    // Merge write data into a word under byte enables
    function automatic logic [31:0] llo_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign req = read_i | write_i;
    assign hit_ovr = (address_i == LLO_OVERRIDE_OFFS);
    assign hit_stat = (address_i == LLO_STATUS_OFFS);

    // Current register contents as a word
    assign ovr_word = {en_q, tx_q, los_q, hys_q, rsvd_q};
    // Status always reports input codes, even under override
    assign stat_word = {LLO_STAT_B31, in_tx_i, in_los_i, in_hys_i, LLO_STAT_LOW};
    assign new_word = llo_merge(ovr_word, writedata_i, byteenable_i);

    // One wait cycle per access, then release for one cycle
    assign waitrequest_o = req & ~ack_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Register fields; write lands at the edge where waitrequest is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_q <= LLO_EN_RST;
            tx_q <= LLO_TX_RST;
            los_q <= LLO_LOS_RST;
            hys_q <= LLO_HYS_RST;
            rsvd_q <= LLO_RSVD_RST;
        end else if (write_i && ack_q && hit_ovr) begin
            en_q <= new_word[LLO_EN_BIT];
            tx_q <= new_word[LLO_TX_HI:LLO_TX_LO];
            los_q <= new_word[LLO_LOS_HI:LLO_LOS_LO];
            hys_q <= new_word[LLO_HYS_HI:LLO_HYS_LO];
            // Reserved bits are plain storage; software keeps them intact
            rsvd_q <= new_word[LLO_RSVD_HI:0];
        end
    end

    // Read data is registered in the wait cycle, stands while acked
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= LLO_UNMAPPED_DATA;
        end else if (read_i && !ack_q) begin
            if (hit_ovr) begin
                rdata_q <= ovr_word;
            end else if (hit_stat) begin
                rdata_q <= stat_word;
            end else begin
                rdata_q <= LLO_UNMAPPED_DATA;
            end
        end
    end
    assign readdata_o = rdata_q;
    assign override_o = en_q;

    // Select between register and input codes
    llo_level_mux #(
        .W(W)
    ) u_mux (
        .override_i(en_q),
        .reg_tx_i(tx_q),
        .reg_los_i(los_q),
        .reg_hys_i(hys_q),
        .in_tx_i(in_tx_i),
        .in_los_i(in_los_i),
        .in_hys_i(in_hys_i),
        .tx_o(tx_o),
        .los_o(los_o),
        .hys_o(hys_o)
    );

    // Override on: applied codes equal register fields
    a_ovr_applies: assert property (@(posedge clk_i) disable iff (!rstn_i)
        en_q |-> (tx_o == tx_q && los_o == los_q && hys_o == hys_q))
        else $error("override on but applied codes differ");
    // Override off: applied codes follow inputs
    a_ovr_off_inputs: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !en_q |-> (tx_o == in_tx_i && los_o == in_los_i && hys_o == in_hys_i))
        else $error("override off but applied codes not from inputs");
    // Full write of amplitude field visible next cycle
    a_tx_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && byteenable_i[3])
        |=> tx_q == $past(writedata_i[LLO_TX_HI:LLO_TX_LO]))
        else $error("amplitude code not written");
    // Threshold field spans two lanes
    a_los_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && byteenable_i[3] && byteenable_i[2])
        |=> los_q == $past(writedata_i[LLO_LOS_HI:LLO_LOS_LO]))
        else $error("threshold code not written");
    // Hysteresis unchanged without a write
    a_hys_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(write_i && ack_q && hit_ovr) |=> $stable(hys_q))
        else $error("hysteresis code changed without write");
    // Status read returns the amplitude input code one cycle after request
    a_stat_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (read_i && !ack_q && hit_stat) |=> ack_q && !waitrequest_o
        && readdata_o[LLO_TX_HI:LLO_TX_LO] == $past(in_tx_i))
        else $error("status read wrong");
    // Each request answered after exactly one wait cycle
    a_bus_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req && !ack_q) |-> waitrequest_o ##1 (ack_q && !waitrequest_o))
        else $error("slave answer timing wrong");
    // Readback of override register matches stored override bit
    a_ovr_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (read_i && !ack_q && hit_ovr) |=> readdata_o[LLO_EN_BIT] == en_q)
        else $error("override readback wrong");

    // Write side: a write counts only at the edge where waitrequest is low
    // Override bit rides in lane 3 with the amplitude
    a_en_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && byteenable_i[3])
        |=> en_q == $past(writedata_i[LLO_EN_BIT]))
        else $error("override bit not written");
    // Hysteresis field sits wholly in lane 2
    a_hys_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && byteenable_i[2])
        |=> hys_q == $past(writedata_i[LLO_HYS_HI:LLO_HYS_LO]))
        else $error("hysteresis code not written");
    // Reserved half is plain storage; keeping it intact is up to software
    a_rsvd_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && byteenable_i[1] && byteenable_i[0])
        |=> rsvd_q == $past(writedata_i[LLO_RSVD_HI:0]))
        else $error("reserved bits not stored");
    // Lane 3 off: override bit and amplitude keep their values
    a_lane_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && ack_q && hit_ovr && !byteenable_i[3])
        |=> $stable(en_q) && $stable(tx_q))
        else $error("disabled lane was written");
    // No taken write, no change of enable, amplitude or threshold
    a_fields_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(write_i && ack_q && hit_ovr) |=> $stable(en_q) && $stable(tx_q) && $stable(los_q))
        else $error("level field changed without write");
    // Writes to status or unmapped places are dropped
    a_refused_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (write_i && !hit_ovr) |=> $stable(ovr_word))
        else $error("refused write changed the register");

    // Read side and idle bus
    // Status read also shows threshold, hysteresis and the fixed bits
    a_stat_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (read_i && !ack_q && hit_stat) |=> readdata_o[LLO_LOS_HI:LLO_LOS_LO] == $past(in_los_i)
        && readdata_o[LLO_HYS_HI:LLO_HYS_LO] == $past(in_hys_i) && readdata_o[LLO_EN_BIT] == LLO_STAT_B31
        && readdata_o[LLO_RSVD_HI:0] == LLO_STAT_LOW)
        else $error("status word fields wrong");
    // Override readback carries the three stored codes and the reserved half
    a_ovr_fields: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (read_i && !ack_q && hit_ovr) |=> readdata_o[LLO_TX_HI:LLO_TX_LO] == tx_q
        && readdata_o[LLO_LOS_HI:LLO_LOS_LO] == los_q && readdata_o[LLO_HYS_HI:LLO_HYS_LO] == hys_q
        && readdata_o[LLO_RSVD_HI:0] == rsvd_q)
        else $error("override field readback wrong");
    // Unmapped read answers with the fixed word, no error
    a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (read_i && !ack_q && !hit_ovr && !hit_stat) |=> readdata_o == LLO_UNMAPPED_DATA)
        else $error("unmapped read data wrong");
    // Read data stands until the next read is taken
    a_read_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(read_i && !ack_q) |=> $stable(readdata_o))
        else $error("read data changed without a read");
    // Idle bus never sees a stall
    a_idle_nowait: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !req |-> !waitrequest_o)
        else $error("waitrequest high with no request");
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench for the link level override register block
`timescale 1ns/1ps
module tb;
    import llo_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [11:0] address_i = 12'h000;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'h0;
    logic [4:0] in_tx_i = 5'h05;
    logic [4:0] in_los_i = 5'h0a;
    logic [4:0] in_hys_i = 5'h1f;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic override_o;
    logic [4:0] tx_o, los_o, hys_o;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] rd, wd;
    logic [4:0] et, el, eh;
    // Ordinary cases: written word; every amplitude code stays at or above the advised floor
    logic [31:0] rows [4] = '{32'h7fff_ffff, 32'hc000_0000, 32'hffff_1234, 32'hc210_0000};
    localparam logic [31:0] RST_WORD = {LLO_EN_RST, LLO_TX_RST, LLO_LOS_RST, LLO_HYS_RST, LLO_RSVD_RST};
    llo_regs i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .in_tx_i(in_tx_i),
        .in_los_i(in_los_i), .in_hys_i(in_hys_i), .override_o(override_o), .tx_o(tx_o),
        .los_o(los_o), .hys_o(hys_o));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Prints counts and verdict, ends the run
    task automatic wrap_up();
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Applied controls packed as enable plus three codes
    task automatic chk_out(input logic ov, input logic [4:0] t, input logic [4:0] l, input logic [4:0] h);
        chk({16'h0, override_o, tx_o, los_o, hys_o}, {16'h0, ov, t, l, h});
    endtask
    // One bus cycle; request held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        write_i <= wr;
        read_i <= ~wr;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                wrap_up();
            end
            @(posedge clk_i);
        end
        // Data taken and request dropped at the answering edge only
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        chk(32'(n), 32'h1);
    endtask
    initial begin
        @(negedge clk_i);
        chk_out(1'b0, 5'h05, 5'h0a, 5'h1f);
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, LLO_OVERRIDE_OFFS, 32'h0, 4'hf, rd);
        chk(rd, RST_WORD);
        // Table of ordinary cases, inputs changed per row
        for (int i = 0; i < 4; i++) begin
            et = 5'(i + 3);
            el = 5'(i + 9);
            eh = 5'(31 - i);
            in_tx_i <= et;
            in_los_i <= el;
            in_hys_i <= eh;
            bus(1'b1, LLO_OVERRIDE_OFFS, rows[i], 4'hf, rd);
            @(negedge clk_i);
            wd = rows[i];
            chk_out(wd[31], wd[31] ? wd[30:26] : et, wd[31] ? wd[25:21] : el, wd[31] ? wd[20:16] : eh);
            bus(1'b0, LLO_OVERRIDE_OFFS, 32'h0, 4'hf, rd);
            chk(rd, wd);
            bus(1'b0, LLO_STATUS_OFFS, 32'h0, 4'hf, rd);
            chk(rd, {LLO_STAT_B31, et, el, eh, LLO_STAT_LOW});
        end
        // Single lane write splits the threshold code across lanes
        bus(1'b1, LLO_OVERRIDE_OFFS, 32'h00ab_0000, 4'h4, rd);
        bus(1'b0, LLO_OVERRIDE_OFFS, 32'h0, 4'hf, rd);
        chk(rd, {wd[31:24], 8'hab, wd[15:0]});
        // Read-modify-write keeps the reserved low half
        wd = {rd[31], 5'h1f, rd[25:0]};
        bus(1'b1, LLO_OVERRIDE_OFFS, wd, 4'hf, rd);
        @(negedge clk_i);
        chk_out(1'b1, 5'h1f, wd[25:21], wd[20:16]);
        // Unmapped and read-only places leave the register alone
        bus(1'b1, 12'h42c, 32'h0, 4'hf, rd);
        bus(1'b1, LLO_STATUS_OFFS, 32'h0, 4'hf, rd);
        bus(1'b0, 12'h42c, 32'h0, 4'hf, rd);
        chk(rd, LLO_UNMAPPED_DATA);
        bus(1'b0, LLO_OVERRIDE_OFFS, 32'h0, 4'hf, rd);
        chk(rd, wd);
        // Reset in mid-run drops the override at once
        rstn_i <= 1'b0;
        @(negedge clk_i);
        chk_out(1'b0, et, el, eh);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, LLO_OVERRIDE_OFFS, 32'h0, 4'hf, rd);
        chk(rd, RST_WORD);
        wrap_up();
    end
endmodule
